/* File: btx_pkg.sv */
// constants shared by the bit-test-skip and bit-toggle execution unit
// assumes one mclk_i edge per q phase, four phases per instruction cycle
package btx_pkg;
    // -----------------------------------------------------------------
    // instruction word layout
    // -----------------------------------------------------------------
    localparam int INSTR_W = 16;
    localparam int OPC_HI = 15;
    localparam int OPC_LO = 12;
    localparam int BIT_HI = 11;
    localparam int BIT_LO = 9;
    localparam int ASEL_POS = 8;
    localparam int FILE_HI = 7;
    localparam int FILE_LO = 0;
    localparam logic [3:0] OPC_SKIP_IF_BIT_SET = 4'ha;
    localparam logic [3:0] OPC_TOGGLE_BIT = 4'h7;

    // -----------------------------------------------------------------
    // data memory addressing
    // -----------------------------------------------------------------
    localparam int DADDR_W = 12;
    localparam int BANK_W = 4;
    localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

    // -----------------------------------------------------------------
    // q phases and filler cycles
    // -----------------------------------------------------------------
    localparam logic [1:0] Q1 = 2'h0;
    localparam logic [1:0] Q2 = 2'h1;
    localparam logic [1:0] Q3 = 2'h2;
    localparam logic [1:0] Q4 = 2'h3;
    localparam logic [1:0] FILL_ONE_WORD = 2'h1;
    localparam logic [1:0] FILL_TWO_WORD = 2'h2;

    typedef enum logic [3:0] {
        BTX_IDLE = 4'h1,
        BTX_SKIPSET = 4'h2,
        BTX_TOGGLE = 4'h4,
        BTX_FILL = 4'h8
    } btx_state_t;
endpackage

/* File: btx_exec.sv */
// execution unit for the skip-if-bit-set and bit-toggle instructions
// assumes data memory answers a q2 read strobe with data valid during q3,
// and that the fetch unit flags whether the prefetched word is two-word
//
// Contract
// RL1 - skip-if-set reads the register; selected bit one skips the next instruction
// RL2 - taken skip discards prefetched word, runs a no-operation cycle instead
// RL3 - skipping a two-word instruction makes the whole thing three cycles
// RL4 - every filler cycle does nothing in all four phases
// RL5 - access select zero uses access bank, one uses bank select register
// RL6 - access zero with extended set uses indexed offset for file up to 95
// RL7 - toggle inverts only the selected bit of the addressed byte
// RL8 - toggle is one cycle, writes back in q4, touches no flags
module btx_exec
    import btx_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [INSTR_W-1:0] instr_i,
    input wire logic instr_valid_i,
    input wire logic next_two_word_i,
    input wire logic ext_set_en_i,
    input wire logic [BANK_W-1:0] bank_select_reg_i,
    input wire logic [DADDR_W-1:0] index_base_i,
    input wire logic [7:0] dm_rdata_i,
    output logic instr_take_o,
    output logic [1:0] q_phase_o,
    output logic [DADDR_W-1:0] dm_addr_o,
    output logic dm_rd_o,
    output logic dm_we_o,
    output logic [7:0] dm_wdata_o,
    output logic skip_o,
    output logic flush_o,
    output logic nop_cycle_o
);
    btx_state_t state_r;
    btx_state_t state_nxt;
    btx_state_t state_dec;
    logic [1:0] q_r;
    logic [1:0] fill_left_r;
    logic [2:0] bit_sel_r;
    logic [DADDR_W-1:0] addr_r;
    logic [DADDR_W-1:0] addr_nxt;
    logic [7:0] wdata_r;
    logic bit_val_r;
    logic rd_bit;
    logic take_skip;
    logic fill_more;
    logic [3:0] opc;
    logic [7:0] fsel;

    assign opc = instr_i[OPC_HI:OPC_LO];
    assign fsel = instr_i[FILE_HI:FILE_LO];
    assign rd_bit = dm_rdata_i[bit_sel_r];

    // -----------------------------------------------------------------
    // q phase counter
    // -----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            q_r <= Q1;
        end else begin
            q_r <= q_r + 2'h1;
        end
    end
    assign q_phase_o = q_r;

    // -----------------------------------------------------------------
    // sequencing
    // -----------------------------------------------------------------
    assign take_skip = (state_r == BTX_SKIPSET) && (q_r == Q4) && bit_val_r; // [RL1]
    assign fill_more = (state_r == BTX_FILL) && (fill_left_r > FILL_ONE_WORD);
    // no new word is taken while filler cycles are still owed
    assign instr_take_o = (q_r == Q4) && !take_skip && !fill_more;

    // word offered in q4; unknown opcodes run as an idle cycle
    always_comb begin
        state_dec = BTX_IDLE;
        if (instr_valid_i && opc == OPC_SKIP_IF_BIT_SET) begin
            state_dec = BTX_SKIPSET;
        end else if (instr_valid_i && opc == OPC_TOGGLE_BIT) begin
            state_dec = BTX_TOGGLE;
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            BTX_SKIPSET: begin
                if (take_skip) begin
                    state_nxt = BTX_FILL; // [RL2]
                end else if (q_r == Q4) begin
                    state_nxt = state_dec;
                end
            end
            BTX_FILL: begin
                // a discarded two-word instruction keeps us here a second cycle
                if (q_r == Q4) begin
                    state_nxt = fill_more ? BTX_FILL : state_dec; // [RL3]
                end
            end
            default: begin
                if (q_r == Q4) begin
                    state_nxt = state_dec;
                end
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_r <= BTX_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // two filler cycles when the discarded word is the first of a pair
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            fill_left_r <= 2'h0;
        end else if (take_skip) begin
            fill_left_r <= next_two_word_i ? FILL_TWO_WORD : FILL_ONE_WORD; // [RL3]
        end else if ((state_r == BTX_FILL) && (q_r == Q4)) begin
            fill_left_r <= fill_left_r - 2'h1;
        end
    end

    // -----------------------------------------------------------------
    // operand address, formed when the word is taken
    // -----------------------------------------------------------------
    always_comb begin
        if (instr_i[ASEL_POS]) begin
            addr_nxt = {bank_select_reg_i, fsel}; // [RL5]
        end else if (ext_set_en_i && fsel <= INDEXED_LIMIT) begin
            addr_nxt = index_base_i + {4'h0, fsel}; // [RL6]
        end else if (fsel <= INDEXED_LIMIT) begin
            addr_nxt = {ACCESS_LOW_BANK, fsel}; // [RL5]
        end else begin
            addr_nxt = {ACCESS_HIGH_BANK, fsel}; // [RL5]
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            addr_r <= '0;
            bit_sel_r <= 3'h0;
        end else if (instr_take_o && instr_valid_i) begin
            addr_r <= addr_nxt;
            bit_sel_r <= instr_i[BIT_HI:BIT_LO];
        end
    end
    assign dm_addr_o = addr_r;

    // -----------------------------------------------------------------
    // read, process, write back
    // -----------------------------------------------------------------
    // filler cycles never strobe memory
    assign dm_rd_o = (q_r == Q2) && (state_r == BTX_SKIPSET || state_r == BTX_TOGGLE); // [RL4]

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            bit_val_r <= 1'b0;
            wdata_r <= 8'h00;
        end else if (q_r == Q3) begin
            bit_val_r <= rd_bit; // [RL1]
            wdata_r <= dm_rdata_i ^ (8'h01 << bit_sel_r); // [RL7]
        end
    end
    assign dm_wdata_o = wdata_r;
    assign dm_we_o = (state_r == BTX_TOGGLE) && (q_r == Q4); // [RL8]

    assign skip_o = take_skip;
    assign flush_o = take_skip;
    assign nop_cycle_o = (state_r == BTX_FILL); // [RL4]

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    a_skip_cause: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RL1]
        (state_r == BTX_SKIPSET && q_r == Q4) |-> (skip_o == $past(rd_bit)))
        else $error("skip does not follow the tested bit");

    a_skip_one_fill: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RL2]
        (skip_o && !next_two_word_i) |=> nop_cycle_o[*4] ##1 !nop_cycle_o)
        else $error("single skip does not give exactly one filler cycle");

    a_skip_two_fill: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RL3]
        (skip_o && next_two_word_i) |=> nop_cycle_o[*8] ##1 !nop_cycle_o)
        else $error("two-word skip does not give exactly two filler cycles");

    a_fill_quiet: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RL4]
        nop_cycle_o |-> (!dm_rd_o && !dm_we_o && !instr_take_o == (q_r != Q4 || fill_more)))
        else $error("filler cycle performed an operation");

    a_bank_addr: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RL5]
        (instr_take_o && instr_valid_i && instr_i[ASEL_POS])
        |=> dm_addr_o == {$past(bank_select_reg_i), $past(fsel)})
        else $error("bank selected address wrong");

    a_indexed_addr: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RL6]
        (instr_take_o && instr_valid_i && !instr_i[ASEL_POS] && ext_set_en_i
            && fsel <= INDEXED_LIMIT)
        |=> dm_addr_o == $past(index_base_i) + {4'h0, $past(fsel)})
        else $error("indexed literal offset address wrong");

    a_toggle_data: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RL7]
        dm_we_o |-> (dm_wdata_o ^ $past(dm_rdata_i)) == (8'h01 << bit_sel_r))
        else $error("toggle changed the wrong bits");

    a_toggle_cycle: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RL8]
        (state_r == BTX_TOGGLE && q_r == Q1) |-> !dm_we_o ##1 dm_rd_o ##2 dm_we_o
        ##1 !nop_cycle_o)
        else $error("toggle did not write back in q4 of one cycle");

    a_skip_read_only: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RL1]
        (state_r == BTX_SKIPSET) |-> !dm_we_o)
        else $error("skip-if-set wrote data memory");

    a_skip_flush: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RL2]
        skip_o |-> (flush_o && !instr_take_o))
        else $error("taken skip kept the prefetched word");

    a_toggle_take: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RL8]
        dm_we_o |-> instr_take_o)
        else $error("toggle did not finish within one cycle");
endmodule

/* File: btx_exec_tb.sv */
// self-checking bench for the bit-test-skip and bit-toggle execution unit
// assumes the bench stands in for fetch and data memory, one mclk_i edge per q phase
module btx_exec_tb
    import btx_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ---------------------------------------------------------------
    // stimulus and design
    // ---------------------------------------------------------------
    typedef struct {
        logic [15:0] instr;
        logic ext;
        logic [3:0] bank_select_reg;
        logic [11:0] base;
        logic [7:0] rdata;
        logic two;
        logic [11:0] addr;
        logic [7:0] wdata;
        logic skip;
        logic [3:0] fill_ph;
    } btx_row_t;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [15:0] instr_i = 16'h0000;
    logic instr_valid_i = 1'b0;
    logic next_two_word_i = 1'b0;
    logic ext_set_en_i = 1'b0;
    logic [3:0] bank_select_reg_i = 4'h0;
    logic [11:0] index_base_i = 12'h000;
    logic [7:0] dm_rdata_i = 8'h00;
    logic instr_take_o, dm_rd_o, dm_we_o, skip_o, flush_o, nop_cycle_o;
    logic [1:0] q_phase_o;
    logic [11:0] dm_addr_o;
    logic [7:0] dm_wdata_o;
    int fail_count = 0;
    int checked = 0;
    // example byte 75h with bit 4 toggled, index wrap at 12 bits, the 5fh/60h boundary
    // inputs: instr, ext, bank, base, read byte, two-word; then address, write byte, skip, fills
    btx_row_t rows [8] = '{
        '{16'h7882, 1'b0, 4'h0, 12'h000, 8'h75, 1'b0, 12'hf82, 8'h65, 1'b0, 4'h0},
        '{16'h7f10, 1'b0, 4'h5, 12'h000, 8'h00, 1'b0, 12'h510, 8'h80, 1'b0, 4'h0},
        '{16'h705f, 1'b1, 4'h0, 12'hff0, 8'hff, 1'b0, 12'h04f, 8'hfe, 1'b0, 4'h0},
        '{16'h7c60, 1'b1, 4'h0, 12'h300, 8'h0f, 1'b0, 12'hf60, 8'h4f, 1'b0, 4'h0},
        '{16'ha220, 1'b0, 4'h0, 12'h000, 8'h02, 1'b0, 12'h020, 8'h00, 1'b1, 4'h4},
        '{16'ha220, 1'b1, 4'h0, 12'h100, 8'hfd, 1'b1, 12'h120, 8'h00, 1'b0, 4'h0},
        '{16'haeff, 1'b0, 4'ha, 12'h000, 8'h80, 1'b1, 12'hfff, 8'h00, 1'b1, 4'h8},
        '{16'h0f33, 1'b0, 4'h0, 12'h000, 8'hff, 1'b0, 12'h000, 8'h00, 1'b0, 4'h0}};
    btx_exec i_btx_exec (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .instr_i(instr_i),
        .instr_valid_i(instr_valid_i), .next_two_word_i(next_two_word_i),
        .ext_set_en_i(ext_set_en_i), .bank_select_reg_i(bank_select_reg_i),
        .index_base_i(index_base_i), .dm_rdata_i(dm_rdata_i), .instr_take_o(instr_take_o),
        .q_phase_o(q_phase_o), .dm_addr_o(dm_addr_o), .dm_rd_o(dm_rd_o), .dm_we_o(dm_we_o),
        .dm_wdata_o(dm_wdata_o), .skip_o(skip_o), .flush_o(flush_o), .nop_cycle_o(nop_cycle_o));
    initial begin
        forever #2 mclk_i = ~mclk_i;
    end
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask
    task automatic step();
        @(posedge mclk_i);
        #1;
    endtask
    // bounded wait for a q4 that accepts a word
    task automatic wait_take();
        int n;
        for (n = 0; n < 40 && !(instr_take_o === 1'b1 && q_phase_o === Q4); n++) step();
        if (n == 40) begin
            fail_count++;
            end_of_test();
        end
    endtask
    task automatic run(input btx_row_t r);
        logic tg, us;
        int nops;
        tg = r.instr[15:12] == OPC_TOGGLE_BIT;
        us = tg || r.instr[15:12] == OPC_SKIP_IF_BIT_SET;
        nops = 0;
        wait_take();
        instr_i = r.instr;
        instr_valid_i = 1'b1;
        {ext_set_en_i, bank_select_reg_i, index_base_i} = {r.ext, r.bank_select_reg, r.base};
        {dm_rdata_i, next_two_word_i} = {r.rdata, r.two};
        step();
        instr_valid_i = 1'b0;
        if (us) chk("dm_addr_o", dm_addr_o, r.addr);
        step();
        chk("dm_rd_o", dm_rd_o, us);
        step();
        step();
        chk("dm_we_o", dm_we_o, tg);
        if (tg) chk("dm_wdata_o", dm_wdata_o, r.wdata);
        chk("skip_o", skip_o, r.skip);
        chk("flush_o", flush_o, r.skip);
        chk("instr_take_o", instr_take_o, !r.skip);
        repeat (12) begin
            step();
            if (nop_cycle_o === 1'b1) begin
                nops++;
                chk("filler strobes", {dm_rd_o, dm_we_o, skip_o, flush_o}, 4'h0);
            end
        end
        chk("filler phases", nops[15:0], r.fill_ph);
        $display("test done instr %h", r.instr);
    endtask
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (8) @(posedge mclk_i);
        #1;
        rst_n_i = 1'b1;
        foreach (rows[i]) run(rows[i]);
        // reset lands in mid toggle: strobes and address must clear
        wait_take();
        instr_i = rows[1].instr;
        instr_valid_i = 1'b1;
        bank_select_reg_i = rows[1].bank_select_reg;
        step();
        instr_valid_i = 1'b0;
        step();
        chk("dm_rd_o", dm_rd_o, 1'b1);
        rst_n_i = 1'b0;
        step();
        step();
        chk("reset outputs", {dm_rd_o, dm_we_o, nop_cycle_o, skip_o, q_phase_o}, 16'h0);
        chk("reset addr", dm_addr_o, 12'h000);
        rst_n_i = 1'b1;
        step();
        chk("q after release", q_phase_o, Q2);
        step();
        step();
        chk("first take", {q_phase_o, instr_take_o}, {Q4, 1'b1});
        $display("test done reset");
        end_of_test();
    end
endmodule
